/* File: core/usdf_defines.svh */
`ifndef USDF_DEFINES_SVH
`define USDF_DEFINES_SVH

// register indices; byte address is four times the index
`define USDF_IDX_CONFIG 7'h72
`define USDF_IDX_CONTROL 7'h73
`define USDF_IDX_STATUS1 7'h74
`define USDF_IDX_STATUS2 7'h75
`define USDF_IDX_DATA_HI 7'h76
`define USDF_IDX_DATA_LO 7'h77

// control register fields
`define USDF_CTL_TIE 7
`define USDF_CTL_TX_COMPLETE_IRQ_ENABLE 6
`define USDF_CTL_RIE 5
`define USDF_CTL_IDLE_IRQ_ENABLE 4
`define USDF_CTL_TE 3
`define USDF_CTL_RE 2
`define USDF_CTL_RWU 1
// config register fields
`define USDF_CFG_NINE 4
// data high fields
`define USDF_DHI_RX8 7
`define USDF_DHI_TX8 6

// reset values
`define USDF_RST_STATUS1 8'hc0
`define USDF_RST_CONTROL 8'h00
`define USDF_RST_CONFIG 8'h00

// one character time in bit periods, start and stop included
`define USDF_CHAR_BITS_8 4'ha
`define USDF_CHAR_BITS_9 4'hb

`endif

/* File: core/usdf_pkg.sv */
package usdf_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic noise;
    logic frame_err;
    logic parity_err;
  } usdf_rx_char_t;

  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_complete_flag;
    logic rx_buffer_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } usdf_status_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } usdf_tx_char_t;

endpackage

/* File: core/usdf_core.sv */
`timescale 1ns/1ns
`include "usdf_defines.svh"

// Function
// RL1 - tx empty set when buffer empty, sequence-cleared
// RL2 - tx complete set when idle, sequence-cleared
// RL3 - rx full set on buffer load, sequence-cleared
// RL4 - line idle after one high character time
// RL5 - idle needs prior activity, wakeup suppresses
// RL6 - overrun keeps old character, flags overrun
// RL7 - noise flag on non-unanimous sampling
// RL8 - framing flag on zero stop bit
// RL9 - parity flag on wrong parity
// RL10 - noise, framing, parity never interrupt
// RL11 - reset status: tx flags set only
// RL12 - status2 holds only receiver active bit
// RL13 - one data address, both directions buffered
// RL14 - data high: rx bit7, tx bit6
// RL15 - interrupt on tx empty and enable
// RL16 - interrupt on tx complete and enable
// RL17 - enabling transmitter sets both tx flags
// RL18 - disable: finish character, drop queue, release
// RL19 - idle disable releases pin at bit tick
// RL20 - disable only requests stop; reset stops now
// RL21 - rx interrupt on full or overrun
// RL22 - idle interrupt when enabled
// RL23 - wakeup inhibits receiver interrupts
// RL24 - single level interrupt of all conditions
module usdf_core
  import usdf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // transmit shift engine
  output usdf_tx_char_t tx_char,
  output logic tx_char_valid,
  input wire logic tx_take,
  input wire logic tx_busy,
  output logic tx_pin_enable,
  // receive shift engine
  input wire usdf_rx_char_t rx_char,
  input wire logic rx_char_done,
  input wire logic rx_active,
  input wire logic rx_line,
  // baud generator
  input wire logic bit_tick,
  // interrupt
  output logic irq
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic te_prev_q;
  usdf_tx_char_t tx_buf_q;
  logic tx_full_q;
  logic tx_pin_q;
  usdf_rx_char_t rx_buf_q;
  logic raf_q;
  usdf_status_t st_q;
  logic txe_q;
  logic txc_q;
  logic rxf_q;
  logic idle_q;
  logic ovr_q;
  logic nf_q;
  logic fe_q;
  logic pe_q;
  usdf_status_t arm_q;
  logic [3:0] idle_cnt_q;
  logic idle_armed_q;
  logic irq_q;

  logic rst_n;
  logic req;
  logic ack;
  logic [6:0] idx;
  logic wr_data_lo;
  logic wr_data_hi;
  logic rd_data_lo;
  logic rd_status1;
  logic te;
  logic te_rise;
  logic rx_load;
  logic rx_over;
  logic line_idle;
  logic tx_clr;
  logic rx_clr;
  logic [3:0] char_bits;
  logic te_off;

  localparam logic [7:0] rst_status1 = `USDF_RST_STATUS1;

  assign rst_n = rst_sync_q;
  assign st_q = {txe_q, txc_q, rxf_q, idle_q, ovr_q, nf_q, fe_q, pe_q};
  assign te_off = ack & write & (idx == `USDF_IDX_CONTROL) & ~writedata[`USDF_CTL_TE];
  assign req = read | write;
  // request is answered on the edge after it is first seen
  assign ack = req & ~wait_q;
  assign idx = address[8:2];
  assign wr_data_lo = ack & write & (idx == `USDF_IDX_DATA_LO);
  assign wr_data_hi = ack & write & (idx == `USDF_IDX_DATA_HI);
  assign rd_data_lo = ack & read & (idx == `USDF_IDX_DATA_LO);
  assign rd_status1 = ack & read & (idx == `USDF_IDX_STATUS1);
  assign te = ctrl_q[`USDF_CTL_TE];
  assign te_rise = te & ~te_prev_q;
  assign rx_load = rx_char_done & ctrl_q[`USDF_CTL_RE] & ~st_q.rx_buffer_full_flag;
  assign rx_over = rx_char_done & ctrl_q[`USDF_CTL_RE] & st_q.rx_buffer_full_flag;
  assign tx_clr = wr_data_lo;
  assign rx_clr = rd_data_lo;
  assign char_bits = cfg_q[`USDF_CFG_NINE] ? `USDF_CHAR_BITS_9 : `USDF_CHAR_BITS_8;
  assign line_idle = bit_tick & rx_line & (idle_cnt_q == char_bits - 4'h1); // [RL4]

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign tx_char = tx_buf_q;
  assign tx_char_valid = tx_full_q;
  assign tx_pin_enable = tx_pin_q;
  assign irq = irq_q;

  // reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // bus handshake and read data capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q & read) begin
        case (idx)
          `USDF_IDX_CONFIG: rdata_q <= {24'h00_0000, cfg_q};
          `USDF_IDX_CONTROL: rdata_q <= {24'h00_0000, ctrl_q};
          `USDF_IDX_STATUS1: rdata_q <= {24'h00_0000, st_q};
          `USDF_IDX_STATUS2: rdata_q <= {31'h0000_0000, raf_q}; // [RL12]
          `USDF_IDX_DATA_HI: begin
            rdata_q <= {24'h00_0000, rx_buf_q.ninth, tx_buf_q.ninth, 6'h00}; // [RL14]
          end
          `USDF_IDX_DATA_LO: rdata_q <= {24'h00_0000, rx_buf_q.data}; // [RL13]
          default: rdata_q <= 32'h0000_0000;
        endcase
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // control and config registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `USDF_RST_CONTROL;
      cfg_q <= `USDF_RST_CONFIG;
      te_prev_q <= 1'b0;
    end else begin
      te_prev_q <= te;
      if (ack & write & (idx == `USDF_IDX_CONTROL)) begin
        // clearing te only asks for a stop; the engine finishes its character
        ctrl_q <= writedata[7:0]; // [RL20]
      end
      if (ack & write & (idx == `USDF_IDX_CONFIG)) begin
        cfg_q <= writedata[7:0];
      end
    end
  end

  // transmit buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_q <= '0;
      tx_full_q <= 1'b0;
    end else begin
      if (wr_data_hi) begin
        tx_buf_q.ninth <= writedata[`USDF_DHI_TX8]; // [RL14]
      end
      if (wr_data_lo) begin
        tx_buf_q.data <= writedata[7:0]; // [RL13]
      end
      if (!te || te_off) begin
        // queued characters are lost once the transmitter is disabled;
        // dropping them on the disabling write keeps tx_char_valid a plain flop
        tx_full_q <= 1'b0; // [RL18]
      end else if (wr_data_lo) begin
        tx_full_q <= 1'b1; // [RL13]
      end else if (tx_take) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // transmit pin ownership
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_q <= 1'b0; // [RL20]
    end else if (te) begin
      tx_pin_q <= 1'b1;
    end else if (!tx_busy && bit_tick) begin
      // release waits for the engine and lands on a bit boundary
      tx_pin_q <= 1'b0; // [RL18] [RL19]
    end
  end

  // arming of the clear sequences by a status read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= '0;
    end else if (rd_status1) begin
      // the snapshot returned to software is what arms each flag
      arm_q <= rdata_q[7:0];
    end else begin
      if (tx_clr) begin
        arm_q.tx_buffer_empty_flag <= 1'b0;
        arm_q.tx_complete_flag <= 1'b0;
      end
      if (rx_clr) begin
        arm_q.rx_buffer_full_flag <= 1'b0;
        arm_q.idle_flag <= 1'b0;
        arm_q.overrun_flag <= 1'b0;
        arm_q.noise_flag <= 1'b0;
        arm_q.framing_error_flag <= 1'b0;
        arm_q.parity_error_flag <= 1'b0;
      end
    end
  end

  // transmit buffer empty; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txe_q <= rst_status1[7]; // [RL11]
    end else if (te_rise || (!tx_full_q && !wr_data_lo)) begin
      txe_q <= 1'b1; // [RL1] [RL17]
    end else if (tx_clr && arm_q.tx_buffer_empty_flag) begin
      txe_q <= 1'b0; // [RL1]
    end
  end

  // transmit complete; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txc_q <= rst_status1[6]; // [RL11]
    end else if (te_rise || (!tx_full_q && !tx_busy && !wr_data_lo)) begin
      txc_q <= 1'b1; // [RL2] [RL17] [RL18]
    end else if (tx_clr && arm_q.tx_complete_flag) begin
      txc_q <= 1'b0; // [RL2]
    end
  end

  // receive buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q <= '0;
    end else if (rx_load) begin
      rx_buf_q.data <= rx_char.data; // [RL3]
      rx_buf_q.ninth <= cfg_q[`USDF_CFG_NINE] & rx_char.ninth; // [RL14]
    end
  end

  // receive full
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxf_q <= 1'b0;
    end else if (rx_load) begin
      rxf_q <= 1'b1; // [RL3]
    end else if (rx_clr && arm_q.rx_buffer_full_flag) begin
      rxf_q <= 1'b0; // [RL3]
    end
  end

  // noise, framing and parity describe the buffered character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
    end else if (rx_load) begin
      nf_q <= rx_char.noise; // [RL7]
      fe_q <= rx_char.frame_err; // [RL8]
      pe_q <= rx_char.parity_err; // [RL9]
    end else if (rx_clr) begin
      if (arm_q.noise_flag) begin
        nf_q <= 1'b0; // [RL7]
      end
      if (arm_q.framing_error_flag) begin
        fe_q <= 1'b0; // [RL8]
      end
      if (arm_q.parity_error_flag) begin
        pe_q <= 1'b0; // [RL9]
      end
    end
  end

  // overrun drops the new character and leaves the buffer alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_q <= 1'b0;
    end else if (rx_over) begin
      ovr_q <= 1'b1; // [RL6]
    end else if (rx_clr && arm_q.overrun_flag) begin
      ovr_q <= 1'b0; // [RL6]
    end
  end

  // idle line counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 4'h0;
      idle_armed_q <= 1'b0;
    end else if (!rx_line) begin
      idle_cnt_q <= 4'h0;
      idle_armed_q <= 1'b1; // [RL5]
    end else if (line_idle) begin
      idle_cnt_q <= 4'h0;
      idle_armed_q <= 1'b0;
    end else if (bit_tick) begin
      idle_cnt_q <= idle_cnt_q + 4'h1; // [RL4]
    end
  end

  // one report per idle period; wakeup hides it entirely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 1'b0;
    end else if (line_idle && idle_armed_q && !ctrl_q[`USDF_CTL_RWU]) begin
      idle_q <= 1'b1; // [RL5]
    end else if (rx_clr && arm_q.idle_flag) begin
      idle_q <= 1'b0; // [RL5]
    end
  end

  // receiver active, one cycle behind the engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raf_q <= 1'b0;
    end else begin
      raf_q <= rx_active; // [RL12]
    end
  end

  // interrupt request; noise, framing and parity flags stay out of it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (st_q.tx_buffer_empty_flag & ctrl_q[`USDF_CTL_TIE]) // [RL15]
             | (st_q.tx_complete_flag & ctrl_q[`USDF_CTL_TX_COMPLETE_IRQ_ENABLE]) // [RL16]
             | (~ctrl_q[`USDF_CTL_RWU] // [RL23]
                & ((ctrl_q[`USDF_CTL_RIE] & (st_q.rx_buffer_full_flag | st_q.overrun_flag)) // [RL21]
                 | (ctrl_q[`USDF_CTL_IDLE_IRQ_ENABLE] & st_q.idle_flag))); // [RL22] [RL10] [RL24]
    end
  end

endmodule

/* File: tb/usdf_core_properties.sv */
`timescale 1ns/1ns
module usdf_core_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register bus
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // engines
  input wire logic tx_char_valid,
  input wire logic tx_busy,
  input wire logic tx_pin_enable,
  input wire logic rx_active,
  input wire logic bit_tick
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [6:0] idx;
  assign idx = address[8:2];
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  a_wait_back: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  a_data_quiet: assert property (waitrequest |-> readdata == 32'h0)
    else $error("stray read data");
  a_stat2_bits: assert property (!waitrequest && read && idx == 7'h75
    |-> readdata == {31'h0, $past(rx_active, 2)})
    else $error("bad status2");
  a_high_zero: assert property (!waitrequest && read && idx == 7'h76
    |-> readdata[5:0] == 6'h0)
    else $error("bad data high");
  a_char_src: assert property ($rose(tx_char_valid)
    |-> $past(write && !waitrequest && idx == 7'h77))
    else $error("char without write");
  a_pin_tick: assert property ($fell(tx_pin_enable) |-> $past(bit_tick && !tx_busy))
    else $error("pin freed off tick");
  a_pin_busy: assert property (tx_pin_enable && tx_busy |=> tx_pin_enable)
    else $error("pin freed while busy");
endmodule

bind usdf_core usdf_core_checker usdf_core_checker_inst (.clk, .resetn, .address, .read,
  .write, .readdata, .waitrequest, .tx_char_valid, .tx_busy, .tx_pin_enable, .rx_active,
  .bit_tick);

/* File: tb/usdf_far_end.sv */
`timescale 1ns/1ns
module usdf_far_end
  import usdf_pkg::*;
(
  // core engine side
  input wire logic clk,
  input wire usdf_tx_char_t tx_char,
  input wire logic tx_char_valid,
  output logic tx_take,
  output logic tx_busy,
  output usdf_rx_char_t rx_char,
  output logic rx_char_done,
  output logic rx_active,
  output logic rx_line,
  output logic bit_tick,
  // bench side
  input wire logic stall,
  output usdf_tx_char_t last_tx,
  output int n_sent
);
  int left = 0;
  logic [1:0] div = 2'h0;
  assign tx_busy = left != 0;
  initial begin
    {tx_take, rx_char, rx_char_done, rx_active, rx_line, bit_tick} = 17'h2;
    last_tx = '0;
    n_sent = 0;
  end
  // four clocks a bit keeps a character to forty cycles
  always @(posedge clk) begin
    div <= div + 2'h1;
    bit_tick <= div == 2'h3;
    tx_take <= 1'b0;
    if (left != 0)
      left <= left - 1;
    else if (tx_char_valid && !stall) begin
      tx_take <= 1'b1;
      left <= 40;
      last_tx <= tx_char;
      n_sent <= n_sent + 1;
    end
  end
  task automatic send(input usdf_rx_char_t c);
    @(posedge clk);
    rx_active <= 1'b1;
    rx_line <= 1'b0;
    repeat (40) @(posedge clk);
    {rx_char, rx_char_done, rx_active, rx_line} <= {c, 3'b101};
    @(posedge clk);
    // stale character is inverted so nothing reads it by luck
    {rx_char, rx_char_done} <= {~c, 1'b0};
  endtask
endmodule

/* File: tb/usdf_core_tb.sv */
`timescale 1ns/1ns
module usdf_core_tb
  import usdf_pkg::*;
;
  logic clk = 0, resetn = 0, read = 0, write = 0, stall = 0;
  logic [8:0] address = 9'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic waitrequest, tx_char_valid, tx_take, tx_busy, tx_pin_enable;
  logic rx_char_done, rx_active, rx_line, bit_tick, irq;
  logic [7:0] d;
  usdf_tx_char_t tx_char, last_tx;
  usdf_rx_char_t rx_char;
  int n_fail = 0, checked = 0, cyc = 0, n0, n_sent;
  always #25 clk = ~clk;
  usdf_core usdf_core_inst (.clk, .resetn, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .tx_char, .tx_char_valid, .tx_take, .tx_busy, .tx_pin_enable, .rx_char,
    .rx_char_done, .rx_active, .rx_line, .bit_tick, .irq);
  usdf_far_end usdf_far_end_inst (.clk, .tx_char, .tx_char_valid, .tx_take, .tx_busy,
    .rx_char, .rx_char_done, .rx_active, .rx_line, .bit_tick, .stall, .last_tx, .n_sent);
  task conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task ck(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [6:0] i, input logic [7:0] v);
    @(posedge clk);
    write <= 1'b1;
    address <= {i, 2'b00};
    writedata <= {24'h0, v};
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task rd(input logic [6:0] i);
    @(posedge clk);
    read <= 1'b1;
    address <= {i, 2'b00};
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
  endtask
  task rc(input logic [6:0] i, input logic [7:0] e);
    rd(i);
    ck(d, e);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      $display("mismatch %0t timeout", $time);
      conclude;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rc(7'h74, 8'hc0);
    rc(7'h75, 8'h00);
    rc(7'h10, 8'h00);
    wr(7'h73, 8'h88);
    repeat (3) @(posedge clk);
    ck(8'(irq), 8'h1);
    // engine stalls so the cleared flags stay visible
    stall <= 1'b1;
    rc(7'h74, 8'hc0);
    wr(7'h77, 8'h5a);
    repeat (2) @(posedge clk);
    ck(8'(irq), 8'h0);
    rc(7'h74, 8'h00);
    stall <= 1'b0;
    repeat (60) @(posedge clk);
    ck(last_tx.data, 8'h5a);
    rc(7'h74, 8'hc0);
    wr(7'h73, 8'h48);
    repeat (3) @(posedge clk);
    ck(8'(irq), 8'h1);
    wr(7'h73, 8'h08);
    n0 = n_sent;
    wr(7'h77, 8'h11);
    wr(7'h77, 8'h22);
    wr(7'h73, 8'h00);
    ck(8'(tx_pin_enable), 8'h1);
    repeat (60) @(posedge clk);
    ck(8'(tx_pin_enable), 8'h0);
    ck(8'(n_sent - n0), 8'h1);
    ck(last_tx.data, 8'h11);
    rc(7'h74, 8'hc0);
    wr(7'h73, 8'h24);
    usdf_far_end_inst.send({8'h3c, 4'b0100});
    repeat (60) @(posedge clk);
    ck(8'(irq), 8'h1);
    rc(7'h74, 8'hf4);
    rc(7'h77, 8'h3c);
    rc(7'h74, 8'hc0);
    wr(7'h73, 8'h04);
    usdf_far_end_inst.send({8'h81, 4'b0011});
    usdf_far_end_inst.send({8'h7e, 4'b0000});
    repeat (60) @(posedge clk);
    ck(8'(irq), 8'h0);
    rc(7'h74, 8'hfb);
    wr(7'h73, 8'h14);
    repeat (3) @(posedge clk);
    ck(8'(irq), 8'h1);
    rc(7'h77, 8'h81);
    rc(7'h74, 8'hc0);
    wr(7'h73, 8'h36);
    usdf_far_end_inst.send({8'h55, 4'b0000});
    repeat (60) @(posedge clk);
    ck(8'(irq), 8'h0);
    rc(7'h74, 8'he0);
    rd(7'h77);
    wr(7'h72, 8'h10);
    wr(7'h73, 8'h0c);
    wr(7'h76, 8'h40);
    wr(7'h77, 8'h01);
    repeat (60) @(posedge clk);
    ck(8'(last_tx.ninth), 8'h1);
    usdf_far_end_inst.send({8'h00, 4'b1000});
    repeat (60) @(posedge clk);
    rc(7'h76, 8'hc0);
    conclude;
  end
endmodule
